// *** rtl/apt_pkg.sv ***
// constants for the power-management control byte and timer block
package apt_pkg;
	// ****************************************
	// register offsets from the programmable base
	// ****************************************
	localparam logic [3:0]  APT_OFF_ENABLE_HIGH  = 4'h3; // reserved, reads zero
	localparam logic [3:0]  APT_OFF_CONTROL_MAIN = 4'h4; // control byte
	localparam logic [3:0]  APT_OFF_CONTROL_2    = 4'h5; // reserved
	localparam logic [3:0]  APT_OFF_CONTROL_3    = 4'h6; // reserved
	localparam logic [3:0]  APT_OFF_CONTROL_4    = 4'h7; // reserved
	localparam logic [3:0]  APT_OFF_TIMER_BYTE0  = 4'h8; // count bits 7:0
	localparam logic [3:0]  APT_OFF_TIMER_BYTE1  = 4'h9; // count bits 15:8
	localparam logic [11:0] APT_BLOCK_HI_ZERO    = 12'h000; // block spans 16 bytes
	// ****************************************
	// control byte fields and reset values
	// ****************************************
	localparam int          APT_BIT_ROUTE        = 0; // event route select
	localparam int          APT_BIT_RELOAD       = 1; // bus master reload enable
	localparam int          APT_BIT_RELEASE      = 2; // global release
	localparam logic [7:0]  APT_CTRL_RESET       = 8'h00; // control reset value
	localparam logic [7:0]  APT_ZERO_BYTE        = 8'h00; // reserved read value
	// ****************************************
	// timer
	// ****************************************
	localparam int          APT_TMR_WIDTH        = 24; // counter width
	localparam int          APT_TMR_MSB          = 23; // carry watch bit
	localparam logic [23:0] APT_TMR_RESET        = 24'h000000; // cleared on reset
	localparam logic [23:0] APT_TMR_ONE          = 24'h000001; // increment step
endpackage

// *** rtl/apt_pm1.sv ***
// power-management control byte, timer bytes and event routing
`timescale 1ns/1ps
module apt_pm1
	import apt_pkg::*;
(
	input  wire logic        clk,                    // 20 MHz clock
	input  wire logic        nrst,                   // master reset, sync, active low
	input  wire logic [15:0] io_base,                // programmable block base
	input  wire logic [15:0] io_addr,                // system i/o address
	input  wire logic [7:0]  io_wdata,               // write data
	input  wire logic        io_wr,                  // write strobe, one cycle
	input  wire logic        io_rd,                  // read strobe, one cycle
	input  wire logic        timer_input_clock,      // timer clock pin
	input  wire logic        working_state,          // system working
	input  wire logic        timer_carry_enable,     // carry interrupt enable
	input  wire logic        timer_status_clear,     // write-one clear of carry flag
	input  wire logic        system_mgmt_irq_enable, // SMI routing enable
	input  wire logic        bus_master_control_set, // write of one to control bit
	input  wire logic        bus_master_status_clear,// write-one clear of bm status
	input  wire logic        firmware_event_enable,  // firmware enable
	input  wire logic        firmware_status_clear,  // write-one clear of fw status
	output logic [7:0]       io_rdata_q,             // read data, one cycle after io_rd
	output logic             timer_carry_status_q,   // carry flag
	output logic             bus_master_control_q,   // bus master control bit
	output logic             bus_master_status_q,    // bus master status flag
	output logic             firmware_status_q,      // firmware status flag
	output logic [23:0]      timer_count_value_q,    // full timer count
	output logic             sci_req_q,              // SCI request level
	output logic             smi_req_q               // SMI request level
);
	import apt_pkg::*;

	// ****************************************
	// address decode
	// ****************************************
	logic [15:0] rel_addr; // address minus base
	logic        hit;      // inside the 16-byte block
	logic        wr_ctrl;  // write to control byte
	assign rel_addr = io_addr - io_base;
	assign hit      = (rel_addr[15:4] == APT_BLOCK_HI_ZERO);
	assign wr_ctrl  = io_wr && hit && (rel_addr[3:0] == APT_OFF_CONTROL_MAIN);

	// ****************************************
	// timer instance
	// ****************************************
	logic carry_pulse; // msb changed this cycle
	apt_timer u_timer
	(
		.clk               (clk),
		.nrst              (nrst),
		.timer_input_clock (timer_input_clock),
		.working_state     (working_state),
		.count_q           (timer_count_value_q),
		.carry_q           (carry_pulse)
	);

	// ****************************************
	// control byte and flags
	// ****************************************
	logic route_q, route_d;     // event_route_select
	logic reload_q, reload_d;   // bus_master_reload_enable
	logic release_q, release_d; // global_release
	logic tsts_d, bmc_d, bms_d, fws_d; // next flags
	logic release_set;          // write of one to global release

	assign release_set = wr_ctrl && io_wdata[APT_BIT_RELEASE];

	// next control and flag values; sets win over clears
	always_comb
	begin
		route_d   = route_q;
		reload_d  = reload_q;
		release_d = release_q;
		if (wr_ctrl)
		begin
			route_d   = io_wdata[APT_BIT_ROUTE];
			reload_d  = io_wdata[APT_BIT_RELOAD];
			release_d = io_wdata[APT_BIT_RELEASE];
		end
		else if (firmware_status_clear)
		begin
			// clearing firmware status also drops release
			release_d = 1'b0;
		end
		tsts_d = carry_pulse | (timer_carry_status_q & ~timer_status_clear);
		bmc_d  = bus_master_control_set | (bus_master_control_q & ~bus_master_status_clear);
		bms_d  = bus_master_control_set | (bus_master_status_q & ~bus_master_status_clear);
		fws_d  = release_set | (firmware_status_q & ~firmware_status_clear);
	end

	// ****************************************
	// event routing
	// ****************************************
	logic pm_event; // enabled power-management event
	logic sci_d;    // next SCI level
	logic smi_d;    // next SMI level

	// levels, not pulses, so a missed edge cannot lose an event
	always_comb
	begin
		pm_event = timer_carry_status_q & timer_carry_enable;
		sci_d    = 1'b0;
		smi_d    = 1'b0;
		if (route_q)
		begin
			sci_d = pm_event;
		end
		else if (system_mgmt_irq_enable)
		begin
			smi_d = pm_event;
		end
		// reload plus bus master always SCI
		sci_d = sci_d | (reload_q & bus_master_status_q);
		smi_d = smi_d | (firmware_status_q & firmware_event_enable);
	end

	// ****************************************
	// read mux
	// ****************************************
	logic [7:0] rdata_d; // next read byte
	always_comb
	begin
		rdata_d = APT_ZERO_BYTE;
		if (io_rd && hit)
		begin
			unique case (rel_addr[3:0])
				APT_OFF_CONTROL_MAIN: rdata_d = {5'h00, release_q, reload_q, route_q};
				APT_OFF_TIMER_BYTE0:  rdata_d = timer_count_value_q[7:0];
				APT_OFF_TIMER_BYTE1:  rdata_d = timer_count_value_q[15:8];
				// reserved and foreign offsets read zero
				default:              rdata_d = APT_ZERO_BYTE;
			endcase
		end
	end

	// ****************************************
	// register stage
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			route_q              <= APT_CTRL_RESET[APT_BIT_ROUTE];
			reload_q             <= APT_CTRL_RESET[APT_BIT_RELOAD];
			release_q            <= APT_CTRL_RESET[APT_BIT_RELEASE];
			timer_carry_status_q <= 1'b0;
			bus_master_control_q <= 1'b0;
			bus_master_status_q  <= 1'b0;
			firmware_status_q    <= 1'b0;
			sci_req_q            <= 1'b0;
			smi_req_q            <= 1'b0;
			io_rdata_q           <= APT_ZERO_BYTE;
		end
		else
		begin
			route_q              <= route_d;
			reload_q             <= reload_d;
			release_q            <= release_d;
			timer_carry_status_q <= tsts_d;
			bus_master_control_q <= bmc_d;
			bus_master_status_q  <= bms_d;
			firmware_status_q    <= fws_d;
			sci_req_q            <= sci_d;
			smi_req_q            <= smi_d;
			io_rdata_q           <= rdata_d;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	sequence s_carry_set;
		timer_carry_status_q && timer_carry_enable && route_q;
	endsequence

	sequence s_release_write;
		wr_ctrl && io_wdata[APT_BIT_RELEASE];
	endsequence

	a_route_sci: assert property (@(posedge clk) disable iff (!nrst)
		s_carry_set |=> sci_req_q)
		else $error("routed carry event gave no SCI");
	a_route_smi: assert property (@(posedge clk) disable iff (!nrst)
		timer_carry_status_q && timer_carry_enable && !route_q && system_mgmt_irq_enable
		&& !(firmware_status_q && firmware_event_enable) |=> smi_req_q)
		else $error("SMI route failed");
	a_reload_sci: assert property (@(posedge clk) disable iff (!nrst)
		reload_q && bus_master_status_q |=> sci_req_q)
		else $error("reload event gave no SCI");
	a_release_fw: assert property (@(posedge clk) disable iff (!nrst)
		s_release_write ##1 firmware_event_enable |=> smi_req_q)
		else $error("release did not reach SMI");
	a_carry_sticky: assert property (@(posedge clk) disable iff (!nrst)
		timer_carry_status_q && !timer_status_clear |=> timer_carry_status_q)
		else $error("carry flag dropped without clear");
	a_bm_set: assert property (@(posedge clk) disable iff (!nrst)
		bus_master_control_set |=> bus_master_status_q && bus_master_control_q)
		else $error("bus master status not set");
	a_rsvd_zero: assert property (@(posedge clk) disable iff (!nrst)
		io_rd && hit && rel_addr[3:0] == APT_OFF_CONTROL_2 |=> io_rdata_q == APT_ZERO_BYTE)
		else $error("reserved byte read nonzero");
	a_timer_read: assert property (@(posedge clk) disable iff (!nrst)
		io_rd && hit && rel_addr[3:0] == APT_OFF_TIMER_BYTE0 |=> io_rdata_q == $past(timer_count_value_q[7:0]))
		else $error("timer byte read wrong");
	a_req_release: assert property (@(posedge clk) disable iff (!nrst)
		!sci_d |=> !sci_req_q)
		else $error("SCI held without cause");
	a_carry_sci: assert property (@(posedge clk) disable iff (!nrst)
		!timer_carry_enable && !reload_q |=> !sci_req_q)
		else $error("SCI without enable");
endmodule

// *** rtl/apt_timer.sv ***
// power-management timer: synchroniser, 24-bit counter, carry detect
`timescale 1ns/1ps
module apt_timer
	import apt_pkg::*;
(
	input  wire logic        clk,           // 20 MHz system clock
	input  wire logic        nrst,          // sync reset, active low
	input  wire logic        timer_input_clock, // 3.579545 MHz pin
	input  wire logic        working_state, // system is working
	output logic [23:0]      count_q,       // running count
	output logic             carry_q        // pulse on msb change
);
	// ****************************************
	// two-stage synchroniser plus edge history
	// ****************************************
	logic sync1_q;  // first stage, read only by sync2
	logic sync2_q;  // second stage
	logic hist_q;   // previous settled level
	logic [23:0] count_d; // next count
	logic carry_d;        // next carry pulse
	logic tick;           // one timer clock rising edge

	// edge found on settled samples only
	assign tick = sync2_q & ~hist_q;

	// next count, held while the input clock is stopped
	always_comb
	begin
		count_d = count_q;
		carry_d = 1'b0;
		if (tick && working_state)
		begin
			count_d = count_q + APT_TMR_ONE;
		end
		carry_d = count_d[APT_TMR_MSB] ^ count_q[APT_TMR_MSB];
	end

	// register stage
	always_ff @(posedge clk)
	begin
		// reset clears, no other clear path
		if (!nrst)
		begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			hist_q  <= 1'b0;
			count_q <= APT_TMR_RESET;
			carry_q <= 1'b0;
		end
		else
		begin
			sync1_q <= timer_input_clock;
			sync2_q <= sync1_q;
			hist_q  <= sync2_q;
			count_q <= count_d;
			carry_q <= carry_d;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	a_count_holds: assert property (@(posedge clk) disable iff (!nrst)
		!$past(tick) |-> count_q == $past(count_q))
		else $error("timer moved without input edge");
	a_count_steps: assert property (@(posedge clk) disable iff (!nrst)
		$past(tick) && $past(working_state) |-> count_q == $past(count_q) + APT_TMR_ONE)
		else $error("timer missed an increment");
	a_carry_pulse: assert property (@(posedge clk) disable iff (!nrst)
		$changed(count_q[APT_TMR_MSB]) |-> carry_q)
		else $error("msb change without carry");
endmodule

// *** sim/apt_host.sv ***
// host processor model that drives the system i/o bus
`timescale 1ns/1ps
module apt_host
(
	input  wire logic        clk,      // bus clock
	input  wire logic [7:0]  rdata,    // read data from the block
	output logic [15:0]      io_addr,  // i/o address
	output logic [7:0]       io_wdata, // write data
	output logic             io_wr,    // write strobe
	output logic             io_rd     // read strobe
);
	// ****************
	// idle bus values
	// ****************
	initial
	begin
		io_addr  = 16'hFFFF;
		io_wdata = 8'hA5;
		io_wr    = 1'b0;
		io_rd    = 1'b0;
	end
	// one-cycle write; address and data flip after it so stale values never look valid
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk);
		io_addr  = a;
		io_wdata = d;
		io_wr    = 1'b1;
		@(negedge clk);
		io_wr    = 1'b0;
		io_addr  = ~a;
		io_wdata = ~d;
	endtask
	// one-cycle read; data is taken the cycle after the strobe edge
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(negedge clk);
		io_addr = a;
		io_rd   = 1'b1;
		@(negedge clk);
		io_rd   = 1'b0;
		io_addr = ~a;
		d       = rdata;
	endtask
endmodule

// *** sim/testbench.sv ***
// self-checking bench for the control byte and timer block
`timescale 1ns/1ps
module testbench;
	import apt_pkg::*;
	logic        clk = 1'b0, nrst = 1'b0, timer_input_clock = 1'b0, working_state = 1'b0;
	logic        timer_carry_enable = 1'b0, timer_status_clear = 1'b0, system_mgmt_irq_enable = 1'b0;
	logic        bus_master_control_set = 1'b0, bus_master_status_clear = 1'b0;
	logic        firmware_event_enable = 1'b0, firmware_status_clear = 1'b0, tclk_run = 1'b0;
	logic [15:0] io_base = 16'h0000, io_addr;
	logic [7:0]  io_wdata, io_rdata_q, r, d;
	logic        io_wr, io_rd, timer_carry_status_q, bus_master_control_q;
	logic        bus_master_status_q, firmware_status_q, sci_req_q, smi_req_q;
	logic [23:0] timer_count_value_q;
	int          fail_count = 0, checks = 0, ticks = 0;
	int          ctrl_q[$]; // model of the stored control bits, one per write
	// ****************
	// clocks, host and design
	// ****************
	always #25 clk = ~clk;
	// timer pin stands low whenever stopped
	always
	begin
		#139.682;
		timer_input_clock = tclk_run ? ~timer_input_clock : 1'b0;
	end
	// reference count: one per pin rise while working
	always @(posedge timer_input_clock)
		if (working_state)
			ticks++;
	apt_host host (.clk(clk), .rdata(io_rdata_q), .io_addr(io_addr), .io_wdata(io_wdata),
		.io_wr(io_wr), .io_rd(io_rd));
	apt_pm1 dut (.clk(clk), .nrst(nrst), .io_base(io_base), .io_addr(io_addr), .io_wdata(io_wdata),
		.io_wr(io_wr), .io_rd(io_rd), .timer_input_clock(timer_input_clock),
		.working_state(working_state), .timer_carry_enable(timer_carry_enable),
		.timer_status_clear(timer_status_clear), .system_mgmt_irq_enable(system_mgmt_irq_enable),
		.bus_master_control_set(bus_master_control_set), .bus_master_status_clear(bus_master_status_clear),
		.firmware_event_enable(firmware_event_enable), .firmware_status_clear(firmware_status_clear),
		.io_rdata_q(io_rdata_q), .timer_carry_status_q(timer_carry_status_q),
		.bus_master_control_q(bus_master_control_q), .bus_master_status_q(bus_master_status_q),
		.firmware_status_q(firmware_status_q), .timer_count_value_q(timer_count_value_q),
		.sci_req_q(sci_req_q), .smi_req_q(smi_req_q));
	// ****************
	// checking and closing
	// ****************
	// register read bytes against the model
	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error at %0t: read %h expected %h", $time, got, exp);
		end
	endtask
	// status flags and request levels, up to three at once
	task automatic chk_flag(input logic [2:0] got, input logic [2:0] exp);
		checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error at %0t: flags %h expected %h", $time, got, exp);
		end
	endtask
	// full timer count
	task automatic chk_count(input logic [23:0] got, input logic [23:0] exp);
		checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error at %0t: count %h expected %h", $time, got, exp);
		end
	endtask
	// carry model: the top count bit has left its reset level
	function automatic logic carry_model(input int n);
		return ((n >> APT_TMR_MSB) & 1) != 0;
	endfunction
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// timer run of n clock cycles, then a settle wait past the synchroniser
	task automatic run_timer(input int n);
		tclk_run = 1'b1;
		repeat (n) @(negedge clk);
		tclk_run = 1'b0;
		repeat (12) @(negedge clk);
	endtask
	// hang guard, well beyond the whole sequence
	initial
	begin
		repeat (20000) @(posedge clk);
		fail_count++;
		finish_test();
	end
	// ****************
	// main sequence
	// ****************
	initial
	begin
		void'($urandom(59));
		@(negedge clk);
		io_base = 16'($urandom) & 16'h7FF0;
		repeat (20) @(negedge clk);
		nrst = 1'b1;
		// every offset and one outside address read zero after reset
		for (int o = 0; o < 17; o++)
		begin
			host.rd(io_base + 16'(o), r);
			chk_reg(r, APT_ZERO_BYTE);
		end
		$display("test reset done");
		// random control bytes keep only the three live bits; reserved bytes ignore writes
		for (int i = 0; i < 8; i++)
		begin
			d = 8'($urandom);
			host.wr(io_base + 16'(APT_OFF_CONTROL_MAIN), d);
			ctrl_q.push_back(int'(d) & 7);
			// reserved offsets 3, 5, 6 and 7 in turn, never the control byte
			host.wr(io_base + 16'(i % 4 == 0 ? 3 : 4 + i % 4), ~d);
			host.rd(io_base + 16'(APT_OFF_CONTROL_MAIN), r);
			chk_reg(r, 8'(ctrl_q.pop_front()));
			host.rd(io_base + 16'(5 + i % 3), r);
			chk_reg(r, APT_ZERO_BYTE);
		end
		host.wr(io_base + 16'(APT_OFF_CONTROL_MAIN), 8'h00);
		$display("test control done");
		// reload enable with bus master control raises SCI, clearing the status drops it
		@(negedge clk) firmware_status_clear = 1'b1;
		@(negedge clk) firmware_status_clear = 1'b0;
		host.wr(io_base + 16'(APT_OFF_CONTROL_MAIN), 8'h02);
		@(negedge clk) bus_master_control_set = 1'b1;
		@(negedge clk) bus_master_control_set = 1'b0;
		@(negedge clk);
		chk_flag(3'(bus_master_status_q), 3'h1);
		chk_flag(3'(bus_master_control_q), 3'h1);
		chk_flag(3'(sci_req_q), 3'h1);
		host.wr(io_base + 16'(APT_OFF_CONTROL_MAIN), 8'h00);
		@(negedge clk);
		chk_flag(3'(sci_req_q), 3'h0);
		host.wr(io_base + 16'(APT_OFF_CONTROL_MAIN), 8'h02);
		@(negedge clk);
		chk_flag(3'(sci_req_q), 3'h1);
		@(negedge clk) bus_master_status_clear = 1'b1;
		@(negedge clk) bus_master_status_clear = 1'b0;
		@(negedge clk);
		chk_flag({bus_master_status_q, bus_master_control_q, sci_req_q}, 3'h0);
		$display("test reload done");
		// global release sets firmware status, with SMI only when enabled
		for (int en = 0; en < 2; en++)
		begin
			firmware_event_enable = en[0];
			host.wr(io_base + 16'(APT_OFF_CONTROL_MAIN), 8'h04);
			chk_flag(3'(firmware_status_q), 3'h1);
			@(negedge clk);
			chk_flag(3'(smi_req_q), 3'(en));
			@(negedge clk) firmware_status_clear = 1'b1;
			@(negedge clk) firmware_status_clear = 1'b0;
			@(negedge clk);
			chk_flag({1'b0, firmware_status_q, smi_req_q}, 3'h0);
			host.rd(io_base + 16'(APT_OFF_CONTROL_MAIN), r);
			chk_reg(r, APT_ZERO_BYTE);
		end
		$display("test release done");
		// carry path armed towards SCI, so a false carry would show on the request
		timer_carry_enable     = 1'b1;
		system_mgmt_irq_enable = 1'($urandom);
		host.wr(io_base + 16'(APT_OFF_CONTROL_MAIN), 8'h01);
		// timer counts pin rises, holds when stopped or idle, resumes from where it stopped
		working_state = 1'b1;
		run_timer(300);
		chk_count(timer_count_value_q, 24'(ticks));
		chk_flag({timer_carry_status_q, sci_req_q, smi_req_q},
			{carry_model(ticks), carry_model(ticks), 1'b0});
		// write-one clear from the status side leaves the flag low
		@(negedge clk) timer_status_clear = 1'b1;
		@(negedge clk) timer_status_clear = 1'b0;
		@(negedge clk);
		chk_flag(3'(timer_carry_status_q), 3'h0);
		host.wr(io_base + 16'(APT_OFF_TIMER_BYTE0), 8'($urandom));
		host.wr(io_base + 16'(APT_OFF_TIMER_BYTE1), 8'($urandom));
		host.rd(io_base + 16'(APT_OFF_TIMER_BYTE0), r);
		chk_reg(r, 8'(ticks));
		host.rd(io_base + 16'(APT_OFF_TIMER_BYTE1), r);
		chk_reg(r, 8'(ticks >> 8));
		working_state = 1'b0;
		run_timer(100);
		chk_count(timer_count_value_q, 24'(ticks));
		// route select low: a carry would go to SMI when that is enabled
		host.wr(io_base + 16'(APT_OFF_CONTROL_MAIN), 8'h00);
		working_state = 1'b1;
		run_timer(150);
		chk_count(timer_count_value_q, 24'(ticks));
		chk_flag({timer_carry_status_q, sci_req_q, smi_req_q},
			{carry_model(ticks), 1'b0, carry_model(ticks) & system_mgmt_irq_enable});
		// master reset while the timer is stopped clears the count
		nrst = 1'b0;
		repeat (3) @(negedge clk);
		nrst = 1'b1;
		ticks = 0;
		chk_count(timer_count_value_q, APT_TMR_RESET);
		run_timer(60);
		chk_count(timer_count_value_q, 24'(ticks));
		$display("test timer done");
		finish_test();
	end
endmodule
